// ==== logic/gpt_breaker_seq.sv ====
// Purpose: motorized breaker coil and pulse sequencer
// Assumes: close and open requests are one-cycle pulses
// Notes: coil stays energized while the breaker is held closed
`timescale 1ns/1ps
`default_nettype none
module gpt_breaker_seq (
	input wire logic clk,
	input wire logic reset,
	gpt_tick_if.dst tif,
	input wire logic close_req,
	input wire logic open_req,
	input wire gpt_pkg::gpt_time_t uv_time,
	input wire gpt_pkg::gpt_time_t close_time,
	input wire gpt_pkg::gpt_time_t open_time,
	output logic uv_coil,
	output logic close_relay,
	output logic open_relay
);
	typedef enum logic [2:0] {B_IDLE, B_UV, B_CLOSE, B_HELD, B_OPEN} gpt_brk_e;
	gpt_brk_e st_reg;
	gpt_brk_e st_next;
	gpt_pkg::gpt_time_t cnt_reg;
	gpt_pkg::gpt_time_t cnt_next;
	logic uv_reg, cl_reg, op_reg;
	logic uv_next, cl_next, op_next;

	// sequence: coil, then close pulse; open pulse drops the coil
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		if (tif.ce) begin
			if (tif.tick) begin
				cnt_next = cnt_reg + gpt_pkg::TIME_ONE;
			end
			if (open_req) begin
				st_next = B_OPEN;
				cnt_next = '0;
			end else if (close_req && st_reg != B_HELD) begin
				st_next = B_UV;
				cnt_next = '0;
			end else begin
				unique case (st_reg)
					B_IDLE, B_HELD: cnt_next = '0;
					B_UV: if (cnt_reg >= uv_time) begin
						st_next = B_CLOSE;
						cnt_next = '0;
					end
					B_CLOSE: if (cnt_reg >= close_time) begin
						st_next = B_HELD;
						cnt_next = '0;
					end
					B_OPEN: if (cnt_reg >= open_time) begin
						st_next = B_IDLE;
						cnt_next = '0;
					end
				endcase
			end
		end
		uv_next = (st_next == B_UV) || (st_next == B_CLOSE) || (st_next == B_HELD);
		cl_next = (st_next == B_CLOSE);
		op_next = (st_next == B_OPEN);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg <= B_IDLE;
			cnt_reg <= '0;
			uv_reg <= 1'b0;
			cl_reg <= 1'b0;
			op_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			uv_reg <= uv_next;
			cl_reg <= cl_next;
			op_reg <= op_next;
		end
	end

	assign uv_coil = uv_reg;
	assign close_relay = cl_reg;
	assign open_relay = op_reg;
endmodule // gpt_breaker_seq
`default_nettype wire

// ==== logic/gpt_fail_timer.sv ====
// Purpose: delay-on timer that fires after a condition holds for a set time
// Assumes: limit counted in timebase ticks
// Notes: expired stays high while the condition lasts
`timescale 1ns/1ps
`default_nettype none
module gpt_fail_timer (
	input wire logic clk,
	input wire logic reset,
	gpt_tick_if.dst tif,
	input wire logic active,
	input wire gpt_pkg::gpt_time_t limit,
	output logic expired
);
	gpt_pkg::gpt_time_t cnt_reg;
	gpt_pkg::gpt_time_t cnt_next;
	logic exp_reg;
	logic exp_next;

	// count ticks while active, restart on any break
	always_comb begin
		cnt_next = cnt_reg;
		exp_next = exp_reg;
		if (tif.ce) begin
			if (!active) begin
				cnt_next = '0;
				exp_next = 1'b0;
			end else begin
				if (tif.tick && cnt_reg < limit) begin
					cnt_next = cnt_reg + gpt_pkg::TIME_ONE;
				end
				exp_next = (cnt_next >= limit);
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_reg <= '0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			exp_reg <= exp_next;
		end
	end

	assign expired = exp_reg;
endmodule // gpt_fail_timer
`default_nettype wire

// ==== logic/gpt_pkg.sv ====
// Purpose: shared constants and types for the genset protection and transfer block
// Assumes: all time settings arrive in tenths of a second unless named otherwise
// Notes: defaults are the factory values, used by software when it loads the ports
package gpt_pkg;

	// clock and common timebase
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICK_PER_SEC = 10;
	localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_PER_SEC;
	localparam int unsigned TENTHS_PER_MIN = 600;

	// field widths
	localparam int unsigned TIME_W = 20;
	localparam int unsigned PWR_W = 17;
	localparam int unsigned CUR_W = 16;
	localparam int unsigned PHASES = 3;

	typedef logic [TIME_W-1:0] gpt_time_t;
	typedef logic signed [PWR_W-1:0] gpt_power_t;
	typedef logic [CUR_W-1:0] gpt_current_t;

	localparam gpt_time_t TIME_MAX = 20'hFFFFF;
	localparam gpt_time_t TIME_ONE = 20'h00001;

	// factory defaults, times in tenths of a second
	localparam gpt_time_t DEF_REV_FAIL = 20'h00032;
	localparam gpt_time_t DEF_OVL_FAIL = 20'h0001E;
	localparam gpt_time_t DEF_MAINS_WAIT = 20'h0012C;
	localparam gpt_time_t DEF_MAINS_CT = 20'h00005;
	localparam gpt_time_t DEF_BRK_PULSE = 20'h00005;
	localparam logic [6:0] DEF_OC_MULT = 7'h10;
	localparam logic [2:0] DEF_TOPOLOGY = 3'h5;

	// overcurrent reaction: delay in ticks is OC_MULT_SPAN minus the multiplier
	localparam logic [6:0] OC_MULT_SPAN = 7'h41;

	// overcurrent action codes
	localparam logic OC_ACT_SHUTDOWN = 1'b0;
	localparam logic OC_ACT_LOADDUMP = 1'b1;

	// unbalance action codes
	localparam logic [1:0] UNB_NONE = 2'h0;
	localparam logic [1:0] UNB_SHUTDOWN = 2'h1;
	localparam logic [1:0] UNB_LOADDUMP = 2'h2;
	localparam logic [1:0] UNB_WARNING = 2'h3;

	// limit set selection
	localparam logic [1:0] VSEL_SECOND = 2'h1;
	localparam logic [1:0] VSEL_THIRD = 2'h2;

	// connection topology codes
	localparam logic [2:0] TOPO_2PH_L12 = 3'h0;
	localparam logic [2:0] TOPO_2PH_L13 = 3'h1;
	localparam logic [2:0] TOPO_SINGLE = 3'h7;
	localparam logic [2:0] MASK_ALL = 3'h7;
	localparam logic [2:0] MASK_L12 = 3'h3;
	localparam logic [2:0] MASK_L13 = 3'h5;
	localparam logic [2:0] MASK_L1 = 3'h1;

	// phases carried by a connection topology
	function automatic logic [2:0] phase_mask(input logic [2:0] topo);
		logic [2:0] m;
		m = MASK_ALL;
		if (topo == TOPO_2PH_L12) begin
			m = MASK_L12;
		end else if (topo == TOPO_2PH_L13) begin
			m = MASK_L13;
		end else if (topo == TOPO_SINGLE) begin
			m = MASK_L1;
		end
		return m;
	endfunction

endpackage

// ==== logic/gpt_protect_transfer.sv ====
// Purpose: genset power and current protection, load shedding and mains transfer
// Assumes: measurements and settings are synchronous plain inputs
// Notes: times in tenths of a second; the sub-to-add delay is in minutes
`timescale 1ns/1ps
`default_nettype none
module gpt_protect_transfer #(
	parameter int unsigned TICK_CYCLES = gpt_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire gpt_pkg::gpt_power_t gen_power,
	input wire logic [gpt_pkg::PHASES-1:0][gpt_pkg::CUR_W-1:0] gen_current,
	input wire logic mains_ok,
	input wire logic genset_ready,
	input wire logic volt_unbal,
	input wire logic curr_unbal,
	input wire logic load_add_req,
	input wire logic load_sub_req,
	input wire logic fault_clear,
	input wire logic [15:0] rev_limit,
	input wire gpt_pkg::gpt_time_t rev_fail_time,
	input wire gpt_pkg::gpt_current_t oc_limit1,
	input wire gpt_pkg::gpt_current_t oc_limit2,
	input wire gpt_pkg::gpt_current_t oc_limit3,
	input wire logic [1:0] volt_sel,
	input wire logic oc_action,
	input wire logic [6:0] oc_mult,
	input wire logic [15:0] ovl_limit,
	input wire gpt_pkg::gpt_time_t ovl_fail_time,
	input wire logic [15:0] shed_low,
	input wire logic [15:0] shed_high,
	input wire gpt_pkg::gpt_time_t add_delay,
	input wire logic [6:0] sub_add_min,
	input wire gpt_pkg::gpt_time_t mains_wait,
	input wire gpt_pkg::gpt_time_t mains_ct_delay,
	input wire gpt_pkg::gpt_time_t brk_uv_time,
	input wire gpt_pkg::gpt_time_t brk_close_time,
	input wire gpt_pkg::gpt_time_t brk_open_time,
	input wire logic [1:0] volt_unbal_act,
	input wire logic [1:0] curr_unbal_act,
	input wire logic [2:0] mains_topology,
	input wire logic [2:0] gen_topology,
	output logic rev_power_fault,
	output logic oc_fault,
	output logic ovl_fault,
	output logic shutdown_alarm,
	output logic loaddump_alarm,
	output logic warning_alarm,
	output logic load_shed_relay,
	output logic load_add_pulse,
	output logic load_sub_pulse,
	output logic gen_contactor,
	output logic mains_contactor,
	output logic breaker_uv_coil,
	output logic breaker_close_relay,
	output logic breaker_open_relay,
	output logic [2:0] mains_phases,
	output logic [2:0] gen_phases
);
	gpt_tick_if tif ();

	// common tenth-second timebase
	logic [31:0] div_reg;
	logic [31:0] div_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		div_next = div_reg;
		tick_next = 1'b0;
		if (ce) begin
			if (div_reg >= TICK_CYCLES - 1) begin
				div_next = '0;
				tick_next = 1'b1;
			end else begin
				div_next = div_reg + 32'h00000001;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign tif.tick = tick_reg;
	assign tif.ce = ce;

	// measurement compares
	logic feeding;
	logic [17:0] rev_mag;
	gpt_pkg::gpt_current_t oc_lim;
	logic [2:0] gen_mask;
	logic [2:0] phase_over;
	logic rev_cond, oc_cond, ovl_cond;
	gpt_pkg::gpt_time_t oc_delay;
	logic rev_exp, oc_exp, ovl_exp;

	assign feeding = gen_contactor;
	assign rev_mag = 18'(-$signed({gen_power[gpt_pkg::PWR_W-1], gen_power}));
	assign rev_cond = gen_power[gpt_pkg::PWR_W-1] && (rev_mag > {2'h0, rev_limit});
	assign oc_lim = (volt_sel == gpt_pkg::VSEL_SECOND) ? oc_limit2 :
		(volt_sel == gpt_pkg::VSEL_THIRD) ? oc_limit3 : oc_limit1;
	assign gen_mask = gpt_pkg::phase_mask(gen_topology);

	// per-phase overcurrent compare on connected phases
	genvar p;
	generate
		for (p = 0; p < gpt_pkg::PHASES; p++) begin : g_phase
			assign phase_over[p] = gen_mask[p] && (gen_current[p] > oc_lim);
		end
	endgenerate

	assign oc_cond = feeding && (oc_lim != '0) && (|phase_over);
	assign oc_delay = gpt_pkg::gpt_time_t'(gpt_pkg::OC_MULT_SPAN - oc_mult);
	assign ovl_cond = feeding && (ovl_limit != '0) &&
		(gen_power > $signed({1'b0, ovl_limit}));

	gpt_fail_timer u_rev_timer (
		.clk(clk),
		.reset(reset),
		.tif(tif),
		.active(rev_cond),
		.limit(rev_fail_time),
		.expired(rev_exp)
	);

	gpt_fail_timer u_oc_timer (
		.clk(clk),
		.reset(reset),
		.tif(tif),
		.active(oc_cond),
		.limit(oc_delay),
		.expired(oc_exp)
	);

	gpt_fail_timer u_ovl_timer (
		.clk(clk),
		.reset(reset),
		.tif(tif),
		.active(ovl_cond),
		.limit(ovl_fail_time),
		.expired(ovl_exp)
	);

	// sticky faults and combined alarms; a new fault wins over a clear
	logic rev_reg, oc_reg, ovl_reg, sd_reg, ld_reg, wr_reg;
	logic rev_next, oc_next, ovl_next, sd_next, ld_next, wr_next;
	logic sd_ev, ld_ev, wr_ev;

	always_comb begin
		sd_ev = (oc_exp && oc_action == gpt_pkg::OC_ACT_SHUTDOWN) ||
			(volt_unbal && volt_unbal_act == gpt_pkg::UNB_SHUTDOWN) ||
			(curr_unbal && curr_unbal_act == gpt_pkg::UNB_SHUTDOWN);
		ld_ev = rev_exp || ovl_exp || (oc_exp && oc_action == gpt_pkg::OC_ACT_LOADDUMP) ||
			(volt_unbal && volt_unbal_act == gpt_pkg::UNB_LOADDUMP) ||
			(curr_unbal && curr_unbal_act == gpt_pkg::UNB_LOADDUMP);
		wr_ev = (volt_unbal && volt_unbal_act == gpt_pkg::UNB_WARNING) ||
			(curr_unbal && curr_unbal_act == gpt_pkg::UNB_WARNING);
		rev_next = rev_reg;
		oc_next = oc_reg;
		ovl_next = ovl_reg;
		sd_next = sd_reg;
		ld_next = ld_reg;
		wr_next = wr_reg;
		if (ce) begin
			rev_next = rev_exp || (rev_reg && !fault_clear);
			oc_next = oc_exp || (oc_reg && !fault_clear);
			ovl_next = ovl_exp || (ovl_reg && !fault_clear);
			sd_next = sd_ev || (sd_reg && !fault_clear);
			ld_next = ld_ev || (ld_reg && !fault_clear);
			wr_next = wr_ev || (wr_reg && !fault_clear);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rev_reg <= 1'b0;
			oc_reg <= 1'b0;
			ovl_reg <= 1'b0;
			sd_reg <= 1'b0;
			ld_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else begin
			rev_reg <= rev_next;
			oc_reg <= oc_next;
			ovl_reg <= ovl_next;
			sd_reg <= sd_next;
			ld_reg <= ld_next;
			wr_reg <= wr_next;
		end
	end

	// load shedding relay, paced add pulses and unpaced subtract pulses
	logic shed_reg, add_reg, sub_reg;
	logic shed_next, add_next, sub_next;
	gpt_pkg::gpt_time_t since_add_reg, since_sub_reg;
	gpt_pkg::gpt_time_t since_add_next, since_sub_next;
	gpt_pkg::gpt_time_t sub_add_gap;

	assign sub_add_gap = gpt_pkg::gpt_time_t'(sub_add_min * gpt_pkg::TENTHS_PER_MIN);

	always_comb begin
		shed_next = shed_reg;
		add_next = 1'b0;
		sub_next = 1'b0;
		since_add_next = since_add_reg;
		since_sub_next = since_sub_reg;
		if (ce) begin
			if (gen_power > $signed({1'b0, shed_high})) begin
				shed_next = 1'b1;
			end else if (gen_power < $signed({1'b0, shed_low})) begin
				shed_next = 1'b0;
			end
			if (tif.tick && since_add_reg != gpt_pkg::TIME_MAX) begin
				since_add_next = since_add_reg + gpt_pkg::TIME_ONE;
			end
			if (tif.tick && since_sub_reg != gpt_pkg::TIME_MAX) begin
				since_sub_next = since_sub_reg + gpt_pkg::TIME_ONE;
			end
			if (load_sub_req) begin
				sub_next = 1'b1;
				since_sub_next = '0;
			end else if (load_add_req && since_add_reg >= add_delay &&
				since_sub_reg >= sub_add_gap) begin
				add_next = 1'b1;
				since_add_next = '0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shed_reg <= 1'b0;
			add_reg <= 1'b0;
			sub_reg <= 1'b0;
			since_add_reg <= gpt_pkg::TIME_MAX;
			since_sub_reg <= gpt_pkg::TIME_MAX;
		end else begin
			shed_reg <= shed_next;
			add_reg <= add_next;
			sub_reg <= sub_next;
			since_add_reg <= since_add_next;
			since_sub_reg <= since_sub_next;
		end
	end

	// contactor changeover between genset and mains
	typedef enum logic [1:0] {T_GAP, T_MAINS, T_GEN, T_WAIT} gpt_xfer_e;
	gpt_xfer_e xs_reg, xs_next;
	gpt_pkg::gpt_time_t xcnt_reg, xcnt_next;
	logic gc_reg, mc_reg, bcl_reg, bop_reg;
	logic gc_next, mc_next, bcl_next, bop_next;
	logic [2:0] mph_reg, gph_reg;

	always_comb begin
		xs_next = xs_reg;
		xcnt_next = xcnt_reg;
		bcl_next = 1'b0;
		bop_next = 1'b0;
		if (ce) begin
			if (tif.tick) begin
				xcnt_next = xcnt_reg + gpt_pkg::TIME_ONE;
			end
			unique case (xs_reg)
				T_GAP: if (mains_ok && xcnt_reg >= mains_ct_delay) begin
					xs_next = T_MAINS;
					bcl_next = 1'b1;
				end else if (!mains_ok && genset_ready) begin
					xs_next = T_GEN;
				end
				T_MAINS: if (!mains_ok && genset_ready) begin
					xs_next = T_GEN;
					bop_next = 1'b1;
				end
				T_GEN: if (mains_ok) begin
					xs_next = T_WAIT;
					xcnt_next = '0;
				end
				T_WAIT: if (!mains_ok) begin
					xs_next = T_GEN;
				end else if (xcnt_reg >= mains_wait) begin
					xs_next = T_GAP;
					xcnt_next = '0;
				end
			endcase
		end
		gc_next = (xs_next == T_GEN) || (xs_next == T_WAIT);
		mc_next = (xs_next == T_MAINS);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			xs_reg <= T_GAP;
			xcnt_reg <= '0;
			gc_reg <= 1'b0;
			mc_reg <= 1'b0;
			bcl_reg <= 1'b0;
			bop_reg <= 1'b0;
			mph_reg <= gpt_pkg::MASK_ALL;
			gph_reg <= gpt_pkg::MASK_ALL;
		end else begin
			xs_reg <= xs_next;
			xcnt_reg <= xcnt_next;
			gc_reg <= gc_next;
			mc_reg <= mc_next;
			bcl_reg <= bcl_next;
			bop_reg <= bop_next;
			if (ce) begin
				mph_reg <= gpt_pkg::phase_mask(mains_topology);
				gph_reg <= gen_mask;
			end
		end
	end

	gpt_breaker_seq u_breaker (
		.clk(clk),
		.reset(reset),
		.tif(tif),
		.close_req(bcl_reg),
		.open_req(bop_reg),
		.uv_time(brk_uv_time),
		.close_time(brk_close_time),
		.open_time(brk_open_time),
		.uv_coil(breaker_uv_coil),
		.close_relay(breaker_close_relay),
		.open_relay(breaker_open_relay)
	);

	// outputs straight from flip-flops
	assign rev_power_fault = rev_reg;
	assign oc_fault = oc_reg;
	assign ovl_fault = ovl_reg;
	assign shutdown_alarm = sd_reg;
	assign loaddump_alarm = ld_reg;
	assign warning_alarm = wr_reg;
	assign load_shed_relay = shed_reg;
	assign load_add_pulse = add_reg;
	assign load_sub_pulse = sub_reg;
	assign gen_contactor = gc_reg;
	assign mains_contactor = mc_reg;
	assign mains_phases = mph_reg;
	assign gen_phases = gph_reg;
endmodule // gpt_protect_transfer
`default_nettype wire

// ==== logic/gpt_tick_if.sv ====
// Purpose: timebase carrier from the top module to its timers
// Assumes: tick is a one-cycle pulse every tenth of a second
// Notes: ce freezes every timer while low
`timescale 1ns/1ps
`default_nettype none
interface gpt_tick_if;
	logic tick;
	logic ce;
	modport src (output tick, output ce);
	modport dst (input tick, input ce);
endinterface
`default_nettype wire

// ==== verif/gpt_far_side.sv ====
// Purpose: far side model of the mains breaker mechanism
// Assumes: the close coil only latches while the undervoltage coil holds
// Notes: losing the coil or an open pulse trips the breaker
`timescale 1ns/1ps
`default_nettype none
module gpt_far_side (
	input wire logic clk,
	input wire logic reset,
	input wire logic uv_coil,
	input wire logic close_relay,
	input wire logic open_relay,
	output logic closed
);
	logic closed_reg, closed_next;
	// latch follows the relays, a trip wins over a close
	always_comb begin
		closed_next = closed_reg;
		if (close_relay && uv_coil) begin
			closed_next = 1'b1;
		end
		if (open_relay || !uv_coil) begin
			closed_next = 1'b0;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			closed_reg <= 1'b0;
		end else begin
			closed_reg <= closed_next;
		end
	end
	assign closed = closed_reg;
endmodule // gpt_far_side
`default_nettype wire

// ==== verif/gpt_protect_transfer_properties.sv ====
// Purpose: port level checks of the protection and transfer block
// Assumes: times in ticks of TICK_CYCLES clocks
// Notes: bound onto the top module
`timescale 1ns/1ps
`default_nettype none
module gpt_protect_transfer_properties #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire gpt_pkg::gpt_power_t gen_power,
	input wire logic load_sub_req,
	input wire logic [15:0] rev_limit,
	input wire gpt_pkg::gpt_time_t rev_fail_time,
	input wire logic [15:0] shed_low,
	input wire logic [15:0] shed_high,
	input wire logic [6:0] sub_add_min,
	input wire gpt_pkg::gpt_time_t mains_ct_delay,
	input wire gpt_pkg::gpt_time_t brk_uv_time,
	input wire gpt_pkg::gpt_time_t brk_close_time,
	input wire gpt_pkg::gpt_time_t brk_open_time,
	input wire logic volt_unbal,
	input wire logic [1:0] volt_unbal_act,
	input wire logic rev_power_fault,
	input wire logic warning_alarm,
	input wire logic load_shed_relay,
	input wire logic load_add_pulse,
	input wire logic load_sub_pulse,
	input wire logic gen_contactor,
	input wire logic mains_contactor,
	input wire logic breaker_uv_coil,
	input wire logic breaker_close_relay,
	input wire logic breaker_open_relay
);
	logic hi_w, lo_w, rev_w;
	// power comparisons against the shedding and reverse limits
	assign hi_w = gen_power > $signed({1'b0, shed_high});
	assign lo_w = gen_power < $signed({1'b0, shed_low});
	assign rev_w = gen_power[16] && (-gen_power) > $signed({1'b0, rev_limit});
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_shed_set_high: assert property (ce && hi_w |=> load_shed_relay)
		else $error("shed relay not set above high limit");
	a_shed_clear_low: assert property (ce && !hi_w && lo_w |=> !load_shed_relay)
		else $error("shed relay not cleared below low limit");
	a_sub_pulse_next: assert property (ce && load_sub_req |=> load_sub_pulse)
		else $error("subtract pulse missing");
	a_add_after_sub: assert property (load_sub_pulse && sub_add_min != 7'h00 |-> !load_add_pulse [*8])
		else $error("add pulse too soon after subtract");
	a_contactor_gap: assert property ($fell(gen_contactor) && mains_ct_delay >= 20'h00003
		|-> !mains_contactor [*8])
		else $error("mains contactor closed inside the gap");
	a_coil_before_close: assert property ($rose(breaker_close_relay) && brk_uv_time >= 20'h00003
		|-> $past(breaker_uv_coil, 8))
		else $error("close relay without coil time");
	a_close_pulse_len: assert property ($rose(breaker_close_relay) && brk_close_time == 20'h00002
		|-> ##[6:9] $fell(breaker_close_relay))
		else $error("close pulse length wrong");
	a_open_pulse_len: assert property ($rose(breaker_open_relay) && brk_open_time == 20'h00002
		|-> ##[6:9] $fell(breaker_open_relay))
		else $error("open pulse length wrong");
	a_unbal_warning: assert property (ce && volt_unbal && volt_unbal_act == gpt_pkg::UNB_WARNING
		|=> warning_alarm)
		else $error("unbalance warning missing");
	a_rev_fail_time: assert property ($rose(rev_power_fault) && rev_fail_time >= 20'h00002
		|-> $past(rev_w, 2) && $past(rev_w, 5))
		else $error("reverse fault without held condition");
	c_close_done: cover property ($fell(breaker_close_relay));
	c_rev_fault: cover property ($rose(rev_power_fault));
	c_add_pulse: cover property (load_add_pulse);
endmodule // gpt_protect_transfer_properties
bind gpt_protect_transfer gpt_protect_transfer_properties #(.TICK_CYCLES(TICK_CYCLES))
	gpt_protect_transfer_properties_i (.*);
`default_nettype wire

// ==== verif/gpt_protect_transfer_tb.sv ====
// Purpose: self-checking bench for the protection and transfer block
// Assumes: tick every 4 clocks, times set to a few ticks except the 1-minute sub-to-add delay
// Notes: breaker mechanism modelled on the far side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module gpt_protect_transfer_tb;
	logic clk, reset, ce, mains_ok, genset_ready, volt_unbal, curr_unbal, load_add_req, load_sub_req, fault_clear;
	logic oc_action, rev_power_fault, oc_fault, ovl_fault, shutdown_alarm, loaddump_alarm, warning_alarm;
	logic load_shed_relay, load_add_pulse, load_sub_pulse, gen_contactor, mains_contactor, closed;
	logic breaker_uv_coil, breaker_close_relay, breaker_open_relay;
	gpt_pkg::gpt_power_t gen_power;
	logic [gpt_pkg::PHASES-1:0][gpt_pkg::CUR_W-1:0] gen_current;
	logic [15:0] rev_limit, ovl_limit, shed_low, shed_high;
	gpt_pkg::gpt_time_t rev_fail_time, ovl_fail_time, add_delay, mains_wait, mains_ct_delay;
	gpt_pkg::gpt_time_t brk_uv_time, brk_close_time, brk_open_time;
	gpt_pkg::gpt_current_t oc_limit1, oc_limit2, oc_limit3;
	logic [1:0] volt_sel, volt_unbal_act, curr_unbal_act;
	logic [6:0] oc_mult, sub_add_min;
	logic [2:0] mains_topology, gen_topology, mains_phases, gen_phases;
	logic [13:0] outs;
	int failures = 0, samples_checked = 0, cycles = 0;
	assign outs = {breaker_open_relay, breaker_close_relay, breaker_uv_coil, mains_contactor, gen_contactor,
		load_sub_pulse, load_add_pulse, load_shed_relay, warning_alarm, loaddump_alarm, shutdown_alarm,
		ovl_fault, oc_fault, rev_power_fault};
	gpt_protect_transfer #(.TICK_CYCLES(4)) gpt_protect_transfer_i (.*);
	gpt_far_side gpt_far_side_i (.clk(clk), .reset(reset), .uv_coil(breaker_uv_coil),
		.close_relay(breaker_close_relay), .open_relay(breaker_open_relay), .closed(closed));
	// clock and hang guard
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			summarize;
		end
	end
	task automatic summarize;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// waits for one output bit, n counts the edges taken
	task automatic wait_bit(input int b, input logic v, output int n);
		n = 0;
		do begin
			tk(1);
			n++;
		end while (outs[b] !== v && n < 3000);
	endtask
	task automatic clr;
		tk(3);
		@(posedge clk) fault_clear <= 1'b1;
		@(posedge clk) fault_clear <= 1'b0;
		tk(2);
	endtask
	function automatic logic [2:0] exp_mask(input int t);
		return (t == 0) ? 3'h3 : (t == 1) ? 3'h5 : (t == 7) ? 3'h1 : 3'h7;
	endfunction
	task automatic t_topology;
		for (int t = 0; t < 8; t++) begin
			@(posedge clk);
			mains_topology <= 3'(t);
			gen_topology <= 3'(7 - t);
			tk(2);
			`CHK("phases", {exp_mask(t), exp_mask(7 - t)}, {mains_phases, gen_phases})
		end
		@(posedge clk) gen_topology <= 3'h5;
	endtask
	task automatic t_shed;
		@(posedge clk) ce <= 1'b0;
		gen_power <= 17'h00190;
		tk(2);
		`CHK("shed frozen", 1'b0, load_shed_relay)
		@(posedge clk) ce <= 1'b1;
		tk(2);
		`CHK("shed high", 1'b1, load_shed_relay)
		@(posedge clk) gen_power <= 17'h000C8;
		tk(2);
		`CHK("shed hold", 1'b1, load_shed_relay)
		@(posedge clk) gen_power <= 17'h00032;
		tk(2);
		`CHK("shed low", 1'b0, load_shed_relay)
	endtask
	task automatic t_reverse;
		int n;
		repeat (3) begin
			@(posedge clk) gen_power <= 17'h1FF6A;
			tk(6);
			@(posedge clk) gen_power <= 17'h00000;
			tk(2);
		end
		`CHK("rev blips", 1'b0, rev_power_fault)
		@(posedge clk) gen_power <= 17'h1FF6A;
		wait_bit(0, 1'b1, n);
		`CHK("rev delay", 1'b1, n >= 9 && n <= 16)
		tk(1);
		`CHK("rev alarm", 1'b1, loaddump_alarm)
		@(posedge clk) gen_power <= 17'h1FFCE;
		clr;
		tk(20);
		`CHK("rev in limit", 1'b0, rev_power_fault)
		@(posedge clk) gen_power <= 17'h00000;
	endtask
	task automatic t_unbal;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			volt_unbal_act <= 2'(i);
			curr_unbal_act <= 2'(i);
			volt_unbal <= (i < 4);
			curr_unbal <= (i >= 4);
			tk(2);
			`CHK("unbal", (i % 4 == 0) ? 3'h0 : 3'h1 << (i % 4 - 1), {warning_alarm, loaddump_alarm, shutdown_alarm})
			@(posedge clk);
			volt_unbal <= 1'b0;
			curr_unbal <= 1'b0;
			clr;
		end
	endtask
	task automatic t_overload;
		int n;
		@(posedge clk) gen_power <= 17'h000C8;
		tk(20);
		`CHK("ovl off", 1'b0, ovl_fault)
		@(posedge clk) ovl_limit <= 16'h0064;
		wait_bit(2, 1'b1, n);
		`CHK("ovl delay", 1'b1, n >= 5 && n <= 13)
		tk(1);
		`CHK("ovl alarm", 1'b1, loaddump_alarm)
		@(posedge clk) gen_power <= 17'h00000;
		clr;
	endtask
	task automatic t_oc;
		int n, nt;
		@(posedge clk) gen_current <= {3{16'h003C}};
		tk(20);
		`CHK("oc off", 1'b0, oc_fault)
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			volt_sel <= 2'(i + 1);
			oc_mult <= (i == 0) ? 7'h40 : 7'h3C;
			oc_action <= (i == 0);
			oc_limit2 <= (i == 0) ? 16'h0032 : 16'h0000;
			oc_limit3 <= (i == 0) ? 16'h0000 : 16'h0032;
			gen_current <= {3{16'h003C}};
			wait_bit(1, 1'b1, n);
			nt = (i == 0) ? 1 : 5;
			`CHK("oc delay", 1'b1, n >= (nt - 1) * 4 && n <= nt * 4 + 6)
			tk(1);
			`CHK("oc action", (i == 0) ? 2'h2 : 2'h1, {loaddump_alarm, shutdown_alarm})
			@(posedge clk) gen_current <= '0;
			clr;
		end
	endtask
	task automatic t_transfer;
		int n;
		@(posedge clk) mains_ok <= 1'b1;
		wait_bit(9, 1'b0, n);
		`CHK("mains wait", 1'b1, n >= 8)
		wait_bit(10, 1'b1, n);
		`CHK("contactor gap", 1'b1, n >= 8)
		wait_bit(11, 1'b1, n);
		wait_bit(12, 1'b1, n);
		`CHK("coil time", 1'b1, n >= 8)
		wait_bit(12, 1'b0, n);
		`CHK("close pulse", 1'b1, n >= 6 && n <= 9)
		`CHK("closed", 2'h3, {closed, breaker_uv_coil})
		@(posedge clk) mains_ok <= 1'b0;
		wait_bit(13, 1'b1, n);
		wait_bit(13, 1'b0, n);
		`CHK("open pulse", 1'b1, n >= 6 && n <= 9)
		tk(1);
		`CHK("opened", 2'h1, {closed, gen_contactor})
	endtask
	task automatic t_load;
		int n;
		@(posedge clk) load_add_req <= 1'b1;
		wait_bit(7, 1'b1, n);
		wait_bit(7, 1'b1, n);
		`CHK("add spacing", 1'b1, n >= 8 && n <= 16)
		@(posedge clk);
		load_add_req <= 1'b0;
		sub_add_min <= 7'h01;
		load_sub_req <= 1'b1;
		@(posedge clk) load_sub_req <= 1'b0;
		#1;
		`CHK("sub pulse", 1'b1, load_sub_pulse)
		@(posedge clk) load_add_req <= 1'b1;
		wait_bit(7, 1'b1, n);
		`CHK("sub to add", 1'b1, n >= 2390 && n <= 2410)
		@(posedge clk) load_add_req <= 1'b0;
	endtask
	// settings at time zero, then reset and the scenarios
	initial begin
		{clk, ce, reset, genset_ready} = 4'hF;
		{clk, mains_ok, volt_unbal, curr_unbal, load_add_req, load_sub_req, fault_clear, oc_action} = 8'h00;
		{gen_power, gen_current, oc_limit1, oc_limit2, oc_limit3, ovl_limit, volt_sel} = '0;
		{volt_unbal_act, curr_unbal_act, sub_add_min} = '0;
		{rev_limit, shed_low, shed_high} = {16'h0064, 16'h0064, 16'h012C};
		{rev_fail_time, ovl_fail_time, add_delay, mains_wait} = {20'h00003, 20'h00002, 20'h00003, 20'h00003};
		{mains_ct_delay, brk_uv_time, brk_close_time, brk_open_time} = {20'h00003, 20'h00003, 20'h00002, 20'h00002};
		{oc_mult, mains_topology, gen_topology} = {7'h10, 3'h5, 3'h5};
		tk(11);
		`CHK("reset phases", 6'h3F, {mains_phases, gen_phases})
		@(posedge clk) reset <= 1'b0;
		tk(4);
		t_topology;
		t_shed;
		t_reverse;
		t_unbal;
		t_overload;
		t_oc;
		t_transfer;
		t_load;
		summarize;
	end
endmodule // gpt_protect_transfer_tb
`default_nettype wire
